// ===== cbcp_bus_seq.sv
// Bus-cycle sequencer with stop and hold power-down control.
// How it works
// - low address on shared lines in T1
// - latch strobe pulses so partner captures address
// - I/O cycles copy port number to both buses
// - select and status lines valid from T1
// - read and write strobes only after T1
// - three T states, fetch and acknowledge four or six
// - ready low waits, hold request holds
// - status code per cycle type as tabled
// - strobe per cycle type, idle keeps high
// - stop drives status low, floats select, strobes
// - ten T-state kinds, each own outputs
// - latch high only T1; T4-T6 fixed outputs
// - no latch strobe in double-add cycles 2,3
// - select high T4-T6 of interrupt acknowledge
// - power-down by stop instruction or hold
// - stop power-down ignores hold release
// - stop ends on reset or interrupt
// - hold power-down ignores interrupts, ends on release
`timescale 1ns/10ps
module cbcp_bus_seq (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Cycle requests from the execution core.
    input  wire logic        cycle_req,          // A machine cycle is wanted.
    output logic             cycle_ack,          // Request taken this edge.
    input  wire logic [2:0]  cycle_kind,         // One of CYC_* codes.
    input  wire logic        fetch_long,         // Fetch takes six T states.
    input  wire logic        double_add_instruction, // Cycle is 2nd/3rd of double add.
    input  wire logic [15:0] cycle_addr,         // Address, or port number in low byte.
    input  wire logic [7:0]  cycle_wdata,        // Write data.
    output logic             cycle_done,         // Pulse at end of cycle.
    output logic      [7:0]  cycle_rdata,        // Read data from the last read.
    // Power-down control.
    input  wire logic        stop_req,           // Stop instruction executed.
    input  wire logic        interrupt_accepted, // Any accepted interrupt.
    output logic             power_down,         // Power-down mode active.
    // Handshake pins.
    input  wire logic        ready,              // Low inserts wait states.
    input  wire logic        hold_req,           // High requests hold.
    output logic             hold_ack,           // Bus released.
    // Bus pins.
    output logic      [7:0]  low_address_data_lines_o,
    output logic             low_address_data_lines_oe,
    input  wire logic [7:0]  low_address_data_lines_i,
    output logic      [7:0]  high_address_lines,
    output logic             high_address_lines_oe,
    output logic             io_memory_select,
    output logic             io_memory_select_oe,
    output logic             cycle_status_1,
    output logic             cycle_status_0,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    output logic             rw_strobe_oe,
    output logic             interrupt_ack_strobe_n,
    output logic             address_latch_strobe
);
    import cbcp_pkg::*;

    // =====================================================================
    // State.
    // =====================================================================
    typedef struct packed {
        cbcp_state_t state_r;     // Current T state.
        logic [2:0]  kind_r;      // Kind of the current cycle.
        logic [2:0]  len_r;       // Cycle length in T states.
        logic [2:0]  tcnt_r;      // T states done before the current one.
        logic        nolatch_r;   // Latch strobe suppressed this cycle.
        logic        stopped_r;   // Stop-initiated power-down.
        logic        hold_pd_r;   // Hold-initiated power-down.
        logic        out_r;       // Bus is being driven out.
        cbcp_state_t resume_r;    // State to resume after hold.
    } cbcp_seq_t;

    cbcp_seq_t st_r;    // Registered state.
    cbcp_seq_t st_nxt;  // Next state.

    logic [7:0] hi_byte;   // High address byte for this cycle.
    logic       load_addr; // Capture address bytes at request.
    logic       load_rd;   // Capture read data.
    logic       is_read;   // Current kind reads.
    logic       is_write;  // Current kind writes.
    logic       is_io;     // Current kind is I/O, acknowledge or restart idle.
    logic [7:0] addr_lo;   // Latched low byte.
    logic [7:0] addr_hi;   // Latched high byte.

    // I/O cycles put the port number on the high bus as well.
    assign hi_byte = (cycle_kind == CYC_IO_READ || cycle_kind == CYC_IO_WRITE)
                   ? cycle_addr[7:0] : cycle_addr[15:8];

    // Decode the current cycle kind.
    assign is_read  = (st_r.kind_r == CYC_OPCODE_FETCH) || (st_r.kind_r == CYC_MEMORY_READ)
                   || (st_r.kind_r == CYC_IO_READ);
    assign is_write = (st_r.kind_r == CYC_MEMORY_WRITE) || (st_r.kind_r == CYC_IO_WRITE);
    assign is_io    = (st_r.kind_r == CYC_IO_READ) || (st_r.kind_r == CYC_IO_WRITE)
                   || (st_r.kind_r == CYC_INTERRUPT_ACK) || (st_r.kind_r == CYC_IDLE_RESTART);

    // A request is taken when the sequencer stands idle in T1 waiting.
    assign cycle_ack = cycle_req && !st_r.out_r && (st_r.state_r == ST_T1)
                    && !hold_req && !stop_req;
    assign load_addr = cycle_ack;
    // Read data are captured at the end of T3 of a reading cycle.
    assign load_rd   = (st_r.state_r == ST_T3) && is_read && st_r.out_r;

    // =====================================================================
    // Byte holders for the address bytes and the read data.
    // =====================================================================
    cbcp_addr_reg u_lo (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .load    (load_addr),
        .din     (cycle_addr[7:0]),
        .dout    (addr_lo)
    );

    cbcp_addr_reg u_hi (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .load    (load_addr),
        .din     (hi_byte),
        .dout    (addr_hi)
    );

    cbcp_addr_reg u_rd (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .load    (load_rd),
        .din     (low_address_data_lines_i),
        .dout    (cycle_rdata)
    );

    // =====================================================================
    // Next-state logic.
    // =====================================================================
    always_comb begin
        st_nxt     = st_r;
        cycle_done = 1'b0;
        case (st_r.state_r)
            ST_RESET: begin
                st_nxt.state_r = ST_T1;
            end
            ST_T1: begin
                if (st_r.out_r) begin
                    st_nxt.state_r = ST_T2;
                end else if (stop_req) begin
                    // Stop enters power-down directly through the stop state.
                    st_nxt.state_r   = ST_STOP;
                    st_nxt.stopped_r = 1'b1;
                end else if (hold_req) begin
                    st_nxt.state_r   = ST_HOLD;
                    st_nxt.hold_pd_r = 1'b1;
                    st_nxt.resume_r  = ST_T1;
                end else if (cycle_req) begin
                    st_nxt.out_r     = 1'b1;
                    st_nxt.kind_r    = cycle_kind;
                    st_nxt.nolatch_r = double_add_instruction;
                    st_nxt.tcnt_r    = 3'h1;
                    // Acknowledge runs as long as a fetch, so it owns T4 to T6.
                    st_nxt.len_r     = (cycle_kind != CYC_OPCODE_FETCH
                                        && cycle_kind != CYC_INTERRUPT_ACK) ? TCOUNT_NORMAL
                                     : (fetch_long ? TCOUNT_FETCH_LONG : TCOUNT_FETCH_SHORT);
                end
            end
            ST_T2: begin
                st_nxt.tcnt_r  = st_r.tcnt_r + 3'h1;
                st_nxt.state_r = ready ? ST_T3 : ST_WAIT;
            end
            ST_WAIT: begin
                st_nxt.state_r = ready ? ST_T3 : ST_WAIT;
            end
            ST_T3, ST_T4, ST_T5: begin
                if (st_r.tcnt_r + 3'h1 >= st_r.len_r) begin
                    cycle_done    = 1'b1;
                    st_nxt.out_r  = 1'b0;
                    st_nxt.tcnt_r = 3'h0;
                    if (hold_req) begin
                        st_nxt.state_r   = ST_HOLD;
                        st_nxt.hold_pd_r = 1'b1;
                        st_nxt.resume_r  = ST_T1;
                    end else begin
                        st_nxt.state_r = ST_T1;
                    end
                end else begin
                    st_nxt.tcnt_r  = st_r.tcnt_r + 3'h1;
                    st_nxt.state_r = (st_r.state_r == ST_T3) ? ST_T4
                                   : (st_r.state_r == ST_T4) ? ST_T5 : ST_T6;
                end
            end
            ST_T6: begin
                cycle_done     = 1'b1;
                st_nxt.out_r   = 1'b0;
                st_nxt.tcnt_r  = 3'h0;
                st_nxt.state_r = ST_T1;
            end
            ST_STOP: begin
                // Only an accepted interrupt or reset ends stop; hold is ignored.
                if (interrupt_accepted) begin
                    st_nxt.state_r   = ST_T1;
                    st_nxt.stopped_r = 1'b0;
                end
            end
            ST_HOLD: begin
                // Interrupts are ignored; release of hold ends it.
                if (!hold_req) begin
                    st_nxt.state_r   = st_r.resume_r;
                    st_nxt.hold_pd_r = 1'b0;
                end
            end
            default: begin
                st_nxt.state_r = ST_RESET;
            end
        endcase
    end

    // Registers the state; reset lands in the reset T state.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{state_r: ST_RESET, kind_r: CYC_OPCODE_FETCH, len_r: TCOUNT_NORMAL,
                      tcnt_r: 3'h0, nolatch_r: 1'b0, stopped_r: 1'b0, hold_pd_r: 1'b0,
                      out_r: 1'b0, resume_r: ST_T1};
        end else begin
            st_r <= st_nxt;
        end
    end

    // =====================================================================
    // Pin outputs per T-state kind.
    // =====================================================================
    always_comb begin
        // Floated-bus defaults used by reset, stop and hold.
        low_address_data_lines_o  = addr_lo;
        low_address_data_lines_oe = 1'b0;
        high_address_lines        = addr_hi;
        high_address_lines_oe     = 1'b0;
        io_memory_select          = 1'b0;
        io_memory_select_oe       = 1'b0;
        cycle_status_1            = 1'b0;
        cycle_status_0            = 1'b0;
        read_strobe_n             = 1'b1;
        write_strobe_n            = 1'b1;
        rw_strobe_oe              = 1'b0;
        interrupt_ack_strobe_n    = 1'b1;
        address_latch_strobe      = 1'b0;
        case (st_r.state_r)
            ST_T1, ST_T2, ST_WAIT, ST_T3: begin
                // Status valid from T1 for the whole cycle.
                rw_strobe_oe          = 1'b1;
                io_memory_select_oe   = st_r.out_r;
                high_address_lines_oe = st_r.out_r;
                io_memory_select      = is_io;
                case (st_r.kind_r)
                    CYC_OPCODE_FETCH:  {cycle_status_1, cycle_status_0} = STS_OPCODE_FETCH[1:0];
                    CYC_MEMORY_READ:   {cycle_status_1, cycle_status_0} = STS_MEMORY_READ[1:0];
                    CYC_MEMORY_WRITE:  {cycle_status_1, cycle_status_0} = STS_MEMORY_WRITE[1:0];
                    CYC_IO_READ:       {cycle_status_1, cycle_status_0} = STS_IO_READ[1:0];
                    CYC_IO_WRITE:      {cycle_status_1, cycle_status_0} = STS_IO_WRITE[1:0];
                    CYC_INTERRUPT_ACK: {cycle_status_1, cycle_status_0} = STS_INTERRUPT_ACK[1:0];
                    CYC_IDLE_DOUBLE:   {cycle_status_1, cycle_status_0} = STS_IDLE_DOUBLE[1:0];
                    default:           {cycle_status_1, cycle_status_0} = STS_IDLE_RESTART[1:0];
                endcase
                if (st_r.state_r == ST_T1) begin
                    // Address out, latch strobe high unless nolatch_r, strobes inactive.
                    low_address_data_lines_oe = st_r.out_r;
                    address_latch_strobe      = st_r.out_r && !st_r.nolatch_r;
                end else if (st_r.out_r) begin
                    // Data phase: command strobes only now.
                    read_strobe_n             = !is_read;
                    write_strobe_n            = !is_write;
                    interrupt_ack_strobe_n    = (st_r.kind_r != CYC_INTERRUPT_ACK);
                    low_address_data_lines_o  = cycle_wdata;
                    low_address_data_lines_oe = is_write;
                end
            end
            ST_T4, ST_T5, ST_T6: begin
                // Status 1,1, memory select except acknowledge, low lines floated.
                cycle_status_1        = 1'b1;
                cycle_status_0        = 1'b1;
                io_memory_select      = (st_r.kind_r == CYC_INTERRUPT_ACK);
                io_memory_select_oe   = 1'b1;
                high_address_lines_oe = 1'b1;
                rw_strobe_oe          = 1'b1;
            end
            ST_STOP: begin
                // Status low, select and strobes floated.
                cycle_status_1 = 1'b0;
                cycle_status_0 = 1'b0;
            end
            default: begin
            end
        endcase
    end

    assign power_down = st_r.stopped_r || st_r.hold_pd_r;
    assign hold_ack   = (st_r.state_r == ST_HOLD) || (st_r.state_r == ST_STOP);

    // =====================================================================
    // Checks.
    // =====================================================================
    AST_LATCH_T1_ONLY: assert property (@(posedge ref_clk) disable iff (!nrst)
        address_latch_strobe |-> (st_r.state_r == ST_T1) && read_strobe_n && write_strobe_n)
        else $error("Latch strobe outside T1 or with active strobe.");
    AST_STROBE_LATE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_r.state_r == ST_T1) |-> read_strobe_n && write_strobe_n)
        else $error("Command strobe active in T1.");
    AST_STOP_OUT: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_r.state_r == ST_STOP) |-> !cycle_status_1 && !cycle_status_0 && !rw_strobe_oe
        && !io_memory_select_oe && interrupt_ack_strobe_n)
        else $error("Stop state outputs wrong.");
    AST_STOP_STAYS: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_r.state_r == ST_STOP) && !interrupt_accepted |=> (st_r.state_r == ST_STOP))
        else $error("Stop left without interrupt.");
    AST_HOLD_EXIT: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_r.state_r == ST_HOLD) && hold_req |=> (st_r.state_r == ST_HOLD))
        else $error("Hold left while request held.");
    AST_NORMAL_LEN: assert property (@(posedge ref_clk) disable iff (!nrst)
        cycle_ack && cycle_kind != CYC_OPCODE_FETCH && cycle_kind != CYC_INTERRUPT_ACK
        ##2 ready |=> cycle_done)
        else $error("Normal cycle not three T states.");
    AST_WAIT_ON_READY: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_r.state_r == ST_T2) && !ready |=> (st_r.state_r == ST_WAIT))
        else $error("No wait state on ready low.");
    AST_IO_PORT_COPY: assert property (@(posedge ref_clk) disable iff (!nrst)
        cycle_ack && cycle_kind == CYC_IO_WRITE |=> addr_hi == addr_lo)
        else $error("Port number not copied.");
    AST_ACK_SELECT: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_r.state_r == ST_T4) && st_r.kind_r == CYC_INTERRUPT_ACK |-> io_memory_select)
        else $error("Select low in acknowledge T4.");

endmodule : cbcp_bus_seq

// ===== cbcp_pkg.sv
// Package of cycle codes, state codes and timing figures for the bus-cycle sequencer.
package cbcp_pkg;

    // =====================================================================
    // Machine cycle kinds requested by the execution core.
    // =====================================================================
    localparam logic [2:0] CYC_OPCODE_FETCH   = 3'h0; // Opcode fetch cycle.
    localparam logic [2:0] CYC_MEMORY_READ    = 3'h1; // Memory read cycle.
    localparam logic [2:0] CYC_MEMORY_WRITE   = 3'h2; // Memory write cycle.
    localparam logic [2:0] CYC_IO_READ        = 3'h3; // I/O read cycle.
    localparam logic [2:0] CYC_IO_WRITE       = 3'h4; // I/O write cycle.
    localparam logic [2:0] CYC_INTERRUPT_ACK  = 3'h5; // Interrupt acknowledge cycle.
    localparam logic [2:0] CYC_IDLE_DOUBLE    = 3'h6; // Bus idle of the double-add instruction.
    localparam logic [2:0] CYC_IDLE_RESTART   = 3'h7; // Bus idle of restart acknowledge.

    // =====================================================================
    // Status codes {io/memory select, status 1, status 0}.
    // =====================================================================
    localparam logic [2:0] STS_OPCODE_FETCH   = 3'h3; // 011.
    localparam logic [2:0] STS_MEMORY_READ    = 3'h2; // 010.
    localparam logic [2:0] STS_MEMORY_WRITE   = 3'h1; // 001.
    localparam logic [2:0] STS_IO_READ        = 3'h6; // 110.
    localparam logic [2:0] STS_IO_WRITE       = 3'h5; // 101.
    localparam logic [2:0] STS_INTERRUPT_ACK  = 3'h7; // 111.
    localparam logic [2:0] STS_IDLE_DOUBLE    = 3'h2; // 010.
    localparam logic [2:0] STS_IDLE_RESTART   = 3'h7; // 111.

    // =====================================================================
    // Cycle lengths in T states, wait and hold excluded.
    // =====================================================================
    localparam logic [2:0] TCOUNT_NORMAL      = 3'h3; // Ordinary machine cycle.
    localparam logic [2:0] TCOUNT_FETCH_SHORT = 3'h4; // Short opcode fetch.
    localparam logic [2:0] TCOUNT_FETCH_LONG  = 3'h6; // Long opcode fetch.

    // =====================================================================
    // The ten T-state kinds, one-hot.
    // =====================================================================
    typedef enum logic [9:0] {
        ST_T1    = 10'h001,
        ST_T2    = 10'h002,
        ST_T3    = 10'h004,
        ST_T4    = 10'h008,
        ST_T5    = 10'h010,
        ST_T6    = 10'h020,
        ST_WAIT  = 10'h040,
        ST_RESET = 10'h080,
        ST_STOP  = 10'h100,
        ST_HOLD  = 10'h200
    } cbcp_state_t;

    // Reset values of the outputs that are registered.
    localparam logic [7:0] RST_ADDR_BYTE      = 8'h00; // Address and data bytes at reset.

endpackage : cbcp_pkg

// ===== cbcp_addr_reg.sv
// Holds one byte captured on a load pulse; used for bus address and data bytes.
`timescale 1ns/10ps
module cbcp_addr_reg (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Load side.
    input  wire logic       load,
    input  wire logic [7:0] din,
    // Stored byte.
    output logic      [7:0] dout
);
    import cbcp_pkg::*;

    // The whole state of this module.
    typedef struct packed {
        logic [7:0] value_r;
    } cbcp_byte_t;

    cbcp_byte_t st_r;   // Registered state.
    cbcp_byte_t st_nxt; // Next state.

    // Captures the input byte when load is high.
    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.value_r = din;
        end
    end

    // Registers the state on every clock edge.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{value_r: RST_ADDR_BYTE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.value_r;

endmodule : cbcp_addr_reg

// ===== cbcp_mem_model.sv
// Memory and I/O partner with an external address latch on the shared lines.
`timescale 1ns/10ps
module cbcp_mem_model (
    // Clock and reset.
    ref_clk, nrst,
    // Pins seen from the far side.
    ad_o, ad_oe, ale, rd_n, wr_n, slow,
    // Answers to the device.
    ad_i, ready, latched_r, written_r
);
    input  wire logic       ref_clk, nrst, ad_oe, ale, rd_n, wr_n, slow;
    input  wire logic [7:0] ad_o;
    output logic      [7:0] ad_i, latched_r, written_r;
    output logic            ready;
    logic [7:0] pat_r;    // Changing filler while nobody drives the lines.
    logic       waited_r; // One wait already given for this strobe.
    // Capture the low address at the edge where the latch strobe falls.
    always @(posedge ref_clk) if (ale) latched_r <= ad_o;
    // Keep the byte written while the write strobe is low.
    always @(posedge ref_clk) if (!wr_n) written_r <= ad_i;
    // Filler pattern and wait bookkeeping.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pat_r <= 8'h00;
            waited_r <= 1'b0;
        end else begin
            pat_r <= pat_r + 8'h3b;
            waited_r <= !(rd_n && wr_n);
        end
    end
    // A slow partner pulls ready low once per strobe.
    assign ready = !(slow && !(rd_n && wr_n) && !waited_r);
    // Resolve the shared lines; read data is the latched address mixed with a mask.
    assign ad_i = ad_oe ? ad_o : (!rd_n ? latched_r ^ 8'h5a : pat_r);
endmodule : cbcp_mem_model

// ===== cbcp_bus_seq_tb.sv
// Self-checking bench for the bus-cycle sequencer.
`timescale 1ns/10ps
module cbcp_bus_seq_tb;
    import cbcp_pkg::*;
    logic ref_clk, nrst, cycle_req, cycle_ack, fetch_long, double_add_instruction, cycle_done;
    logic stop_req, interrupt_accepted, power_down, ready, hold_req, hold_ack, slow, rd_w, wr_w;
    logic low_address_data_lines_oe, high_address_lines_oe, io_memory_select, io_memory_select_oe;
    logic cycle_status_1, cycle_status_0, read_strobe_n, write_strobe_n, rw_strobe_oe;
    logic interrupt_ack_strobe_n, address_latch_strobe;
    logic [2:0]  cycle_kind;
    logic [15:0] cycle_addr;
    logic [7:0]  cycle_wdata, cycle_rdata, low_address_data_lines_o, low_address_data_lines_i;
    logic [7:0]  high_address_lines, latched, written;
    int          err_count, checks_done, cyc;
    // Expected status and {read, write, acknowledge} strobes, indexed by cycle kind.
    logic [2:0] sts_t[8] = '{STS_OPCODE_FETCH, STS_MEMORY_READ, STS_MEMORY_WRITE, STS_IO_READ,
                             STS_IO_WRITE, STS_INTERRUPT_ACK, STS_IDLE_DOUBLE, STS_IDLE_RESTART};
    logic [2:0] ctl_t[8] = '{3'h3, 3'h3, 3'h5, 3'h3, 3'h5, 3'h6, 3'h7, 3'h7};
    // Floated strobes are pulled high on the board.
    assign rd_w = rw_strobe_oe ? read_strobe_n : 1'b1;
    assign wr_w = rw_strobe_oe ? write_strobe_n : 1'b1;
    cbcp_bus_seq u_cbcp_bus_seq (.*);
    cbcp_mem_model u_cbcp_mem_model (.ref_clk(ref_clk), .nrst(nrst),
        .ad_o(low_address_data_lines_o), .ad_oe(low_address_data_lines_oe),
        .ale(address_latch_strobe), .rd_n(rd_w), .wr_n(wr_w), .slow(slow),
        .ad_i(low_address_data_lines_i), .ready(ready), .latched_r(latched), .written_r(written));
    // Clock of 50 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Compares one result and reports a mismatch at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // Waits a bounded time for the power-down flag to reach a level.
    task automatic wait_pd(input logic v);
        for (int i = 0; i < 10 && power_down !== v; i++) @(negedge ref_clk);
        chk(power_down, v);
    endtask : wait_pd
    // Runs one machine cycle of a kind and judges pins, length and data.
    task automatic do_cycle(input logic [2:0] k, input logic [7:0] len, input logic dbl);
        logic [7:0] n;
        logic [7:0] lo;
        lo = 8'h30 + k;
        cycle_kind <= k;
        double_add_instruction <= dbl;
        cycle_addr <= {8'hc0 + k, lo};
        cycle_wdata <= ~lo;
        cycle_req <= 1'b1;
        n = 8'h00;
        do begin @(negedge ref_clk); n++; end while (cycle_ack !== 1'b1 && n < 8'h20);
        @(posedge ref_clk) cycle_req <= 1'b0;
        @(negedge ref_clk);
        chk({io_memory_select, cycle_status_1, cycle_status_0}, sts_t[k]);
        chk({rd_w, wr_w, interrupt_ack_strobe_n, address_latch_strobe}, {3'h7, !dbl});
        chk(high_address_lines, (k == CYC_IO_READ || k == CYC_IO_WRITE) ? lo : 8'hc0 + k);
        @(negedge ref_clk);
        chk({rd_w, wr_w, interrupt_ack_strobe_n}, ctl_t[k]);
        n = 8'h02;
        while (cycle_done !== 1'b1 && n < 8'h20) begin @(negedge ref_clk); n++; end
        chk(n, len);
        if (k == CYC_OPCODE_FETCH || k == CYC_INTERRUPT_ACK) chk({cycle_status_1, cycle_status_0,
            io_memory_select, low_address_data_lines_oe, rd_w, wr_w, interrupt_ack_strobe_n},
            {2'h3, k == CYC_INTERRUPT_ACK, 4'h7});
        @(posedge ref_clk) #1;
        if (!dbl) chk(latched, lo);
        if (!ctl_t[k][2]) chk(cycle_rdata, lo ^ 8'h5a);
        if (!ctl_t[k][1]) chk(written, ~lo);
    endtask : do_cycle
    // Stop power-down ignores a hold pulse and ends on an interrupt.
    task automatic stop_case();
        @(posedge ref_clk) stop_req <= 1'b1;
        wait_pd(1'b1);
        @(posedge ref_clk) stop_req <= 1'b0;
        chk({cycle_status_1, cycle_status_0, interrupt_ack_strobe_n, rw_strobe_oe,
             io_memory_select_oe}, 8'h04);
        hold_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hold_req <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(power_down, 1'b1);
        @(posedge ref_clk) interrupt_accepted <= 1'b1;
        wait_pd(1'b0);
        @(posedge ref_clk) interrupt_accepted <= 1'b0;
    endtask : stop_case
    // Hold power-down floats the bus, ignores interrupts and ends on release.
    task automatic hold_case();
        @(posedge ref_clk) hold_req <= 1'b1;
        wait_pd(1'b1);
        chk({hold_ack, low_address_data_lines_oe, high_address_lines_oe, io_memory_select_oe,
             rw_strobe_oe, interrupt_ack_strobe_n, address_latch_strobe}, 8'h42);
        @(posedge ref_clk) interrupt_accepted <= 1'b1;
        repeat (3) @(posedge ref_clk);
        interrupt_accepted <= 1'b0;
        @(negedge ref_clk);
        chk(power_down, 1'b1);
        @(posedge ref_clk) hold_req <= 1'b0;
        wait_pd(1'b0);
    endtask : hold_case
    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    // Main sequence: reset, every cycle kind, long fetch, slow partner, power-down.
    initial begin
        {nrst, cycle_req, fetch_long, double_add_instruction, stop_req} = 5'h00;
        {interrupt_accepted, hold_req, slow, cycle_kind, cycle_addr, cycle_wdata} = 30'h0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        for (int k = 0; k < 8; k++) do_cycle(k[2:0], (k == 0 || k == 5) ? 8'h04 : 8'h03, k == 6);
        fetch_long <= 1'b1;
        do_cycle(CYC_OPCODE_FETCH, 8'h06, 1'b0);
        fetch_long <= 1'b0;
        slow <= 1'b1;
        do_cycle(CYC_MEMORY_READ, 8'h04, 1'b0);
        slow <= 1'b0;
        stop_case();
        hold_case();
        do_cycle(CYC_IO_WRITE, 8'h03, 1'b0);
        wrap_up();
    end
endmodule : cbcp_bus_seq_tb
